// >>> core/digitizer_ctrl.sv
// Purpose: Clamp timing, gain latch, offset DAC steering and output format control
// Assumes: sys_clk is the recovered pixel clock; one pixel per cycle
// Notes: APB slave with zero wait states; registers one per word, index * 4
//
// Functional notes
// - Config bit 2 selects YUV, else RGB
// - YUV black on chroma channels is 0x80
// - No colour space conversion ever
// - Y on green; green/blue/red carry Y/U/V
// - 4:2:2: blue low, red alternates U/V
// - Default AC coupled; bit 1 DC, no clamp
// - AC: clamp once per line after sync
// - Bit 5 low suppresses clamp while coasting
// - Clamp starts when count reaches start value
// - Clamp lasts exactly programmed width pixels
// - Green sync slicer settings from register sync_on_green_slicer
// - Three sync sources with activity detection
// - Gain is 0.5 plus code over 170
// - Gain applied by clamp pulse or idle timeout
// - Without clamp pulses gain applies within 100ms
// - Bandwidth field 3:1, widest default
// - Peaking field 7:4, zero disables
// - Loop drives offset DAC normally
// - Loop on: offsets are digital adders
// - Loop off: DAC from offset and low bits
// - Range bit halves DAC swing
// - Loop measures black once per line
// - Offset 0x80 gives nominal black
`timescale 1ns/1ps
`default_nettype none
module digitizer_ctrl
  import digitizer_ctrl_pkg::*;
#(
  parameter int GAIN_TIMEOUT = GAIN_TIMEOUT_CYC
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic hsync_in,
  input wire logic ext_clamp_in,
  input wire logic pixel_clock_loop_coast,
  input wire logic [2:0] sync_activity,
  input wire pixel_s adc_pixel,
  input wire logic [29:0] auto_black_level_loop_dac,
  output pixel_s out_pixel,
  output logic clamp_on,
  output logic black_measure_on,
  output logic [23:0] channel_gain_value,
  output logic [29:0] offset_dac_code,
  output logic offset_dac_half_range,
  output logic auto_black_level_loop_en,
  output logic [2:0] bandwidth_sel,
  output logic [3:0] peaking_sel,
  output logic [7:0] sync_on_green_cfg,
  output logic [2:0] clamp_impedance_sel
);

  // ************************************************************
  // Parameter check
  // ************************************************************
  if (GAIN_TIMEOUT < 1 || GAIN_TIMEOUT > 24'hffffff) begin : g_bad_timeout
    $error("GAIN_TIMEOUT out of range");
  end

  // ************************************************************
  // Register file
  // ************************************************************
  logic [7:0] regs_r [0:63]; // Sparse map, only decoded indices take writes
  logic [5:0] idx; // Word index of the APB address
  logic mapped; // Address decodes to a register
  logic acc; // Access phase completes this cycle
  logic [31:0] prdata_r; // Read data captured in setup
  logic err_r; // Unmapped flag captured in setup
  logic [7:0] status; // Own state shown to software

  assign idx = paddr[7:2];
  assign acc = psel && penable;
  assign pready = acc; // Zero wait states
  assign pslverr = acc && err_r;
  assign prdata = prdata_r;

  // Address decode
  always_comb begin
    if (paddr[1:0] != 2'b00) begin
      mapped = 1'b0;
    end else if (idx >= IDX_SYNC_ON_GREEN_SLICER && idx <= IDX_BANDWIDTH_AND_PEAKING) begin
      mapped = 1'b1;
    end else if (idx >= IDX_CLAMP_SOURCE_SELECT && idx <= IDX_OUTPUT_FORMAT_CONFIG) begin
      mapped = 1'b1;
    end else if (idx == IDX_CLAMP_IMPEDANCE || idx == IDX_CONTROL_STATUS) begin
      mapped = 1'b1;
    end else begin
      mapped = 1'b0;
    end
  end

  // Writes land at the access edge; status is read only
  genvar gi;
  generate
    for (gi = 0; gi < 64; gi++) begin : g_reg
      localparam logic [5:0] I = 6'(gi);
      localparam logic [7:0] RV = (I >= IDX_RED_GAIN && I <= IDX_BLUE_GAIN) ? RST_GAIN :
                                  (I >= IDX_RED_OFFSET && I <= IDX_BLUE_OFFSET) ? RST_OFFSET :
                                  (I == IDX_BANDWIDTH_AND_PEAKING) ? RST_BANDWIDTH :
                                  (I == IDX_CLAMP_IMPEDANCE) ? RST_CLAMP_IMPEDANCE : RST_ZERO;
      always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
          regs_r[gi] <= RV;
        end else if (acc && pwrite && mapped && idx == I && I != IDX_CONTROL_STATUS) begin
          regs_r[gi] <= pwdata[7:0];
        end
      end
    end
  endgenerate

  // Read data and error captured in setup, held through access
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      prdata_r <= 32'h0000_0000;
      err_r <= 1'b0;
    end else if (psel && !penable) begin
      err_r <= !mapped;
      if (!mapped || pwrite) begin
        prdata_r <= 32'h0000_0000;
      end else if (idx == IDX_CONTROL_STATUS) begin
        prdata_r <= {24'h00_0000, status};
      end else begin
        prdata_r <= {24'h00_0000, regs_r[idx]};
      end
    end
  end

  // Decoded configuration
  logic yuv_mode, dc_coupled, clamp_in_coast, fmt_422, ext_clamp_sel;
  assign yuv_mode = regs_r[IDX_INPUT_CONFIGURATION][CFG_YUV_BIT];
  assign dc_coupled = regs_r[IDX_INPUT_CONFIGURATION][CFG_DC_COUPLED_BIT];
  assign clamp_in_coast = regs_r[IDX_INPUT_CONFIGURATION][CFG_CLAMP_IN_COAST_BIT];
  assign fmt_422 = regs_r[IDX_OUTPUT_FORMAT_CONFIG][FMT_422_BIT];
  assign ext_clamp_sel = |regs_r[IDX_CLAMP_SOURCE_SELECT][EXT_CLAMP_LSB +: 2];
  assign auto_black_level_loop_en = !regs_r[IDX_BLACK_LEVEL_LOOP_CONFIG][LOOP_DISABLE_BIT];
  assign offset_dac_half_range = regs_r[IDX_OFFSET_LOW_BITS_AND_RANGE][RANGE_HALF_BIT];
  assign bandwidth_sel = regs_r[IDX_BANDWIDTH_AND_PEAKING][3:1];
  assign peaking_sel = regs_r[IDX_BANDWIDTH_AND_PEAKING][7:4];
  assign sync_on_green_cfg = regs_r[IDX_SYNC_ON_GREEN_SLICER];
  assign clamp_impedance_sel = regs_r[IDX_CLAMP_IMPEDANCE][6:4];

  // ************************************************************
  // Pin synchronisers and edge detect
  // ************************************************************
  logic [1:0] hs_sync_r, ec_sync_r, act_sync_r [0:2]; // Two-flop chains
  logic hs_last_r, ec_last_r; // Previous synchronised level
  logic hs_trail, ec_rise;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      hs_sync_r <= 2'b00;
      ec_sync_r <= 2'b00;
      hs_last_r <= 1'b0;
      ec_last_r <= 1'b0;
    end else begin
      hs_sync_r <= {hs_sync_r[0], hsync_in};
      ec_sync_r <= {ec_sync_r[0], ext_clamp_in};
      hs_last_r <= hs_sync_r[1];
      ec_last_r <= ec_sync_r[1];
    end
  end

  // Activity flags from the sync slicers cross in too
  generate
    for (gi = 0; gi < 3; gi++) begin : g_act
      always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
          act_sync_r[gi] <= 2'b00;
        end else begin
          act_sync_r[gi] <= {act_sync_r[gi][0], sync_activity[gi]};
        end
      end
    end
  endgenerate

  // Sync is active high, so its trailing edge is the fall
  assign hs_trail = hs_last_r && !hs_sync_r[1];
  assign ec_rise = !ec_last_r && ec_sync_r[1];

  // ************************************************************
  // Clamp timing
  // ************************************************************
  logic [15:0] pix_cnt_r; // Pixels since trailing edge
  logic [7:0] width_r; // Clamp pixels remaining
  logic armed_r; // One clamp per line
  logic coast_seen_r; // Loop coasted during this line
  logic [15:0] start_px;
  logic win_start, suppress, clamp_pulse;

  assign start_px = {regs_r[IDX_CLAMP_START_PIXEL_HIGH], regs_r[IDX_CLAMP_START_PIXEL_LOW]};
  assign win_start = armed_r && !hs_trail && pix_cnt_r == start_px;
  // Whole line is suppressed once coasting is seen, so the porch never sees a glitch
  assign suppress = !clamp_in_coast && (coast_seen_r || pixel_clock_loop_coast);
  assign clamp_pulse = win_start && !suppress;

  // Pixel counter, saturates on very long lines
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pix_cnt_r <= 16'h0000;
    end else if (hs_trail) begin
      pix_cnt_r <= 16'h0000;
    end else if (pix_cnt_r != 16'hffff) begin
      pix_cnt_r <= pix_cnt_r + 16'h0001;
    end
  end

  // Arm on each line, disarm at the start pixel
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      armed_r <= 1'b0;
    end else if (hs_trail) begin
      armed_r <= 1'b1;
    end else if (win_start) begin
      armed_r <= 1'b0;
    end
  end

  // Coast seen; a coast at the edge itself is not lost
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      coast_seen_r <= 1'b0;
    end else if (hs_trail) begin
      coast_seen_r <= pixel_clock_loop_coast;
    end else if (pixel_clock_loop_coast) begin
      coast_seen_r <= 1'b1;
    end
  end

  // Width down-counter, cleared on each edge, loaded by the clamp pulse
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      width_r <= 8'h00;
    end else if (hs_trail) begin
      width_r <= 8'h00;
    end else if (clamp_pulse) begin
      width_r <= regs_r[IDX_CLAMP_WIDTH];
    end else if (width_r != 8'h00) begin
      width_r <= width_r - 8'h01;
    end
  end

  assign clamp_on = !dc_coupled && width_r != 8'h00;

  // Clamp pulses since the last trailing edge, saturating; guards one per line
  logic [1:0] line_clamps_r;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      line_clamps_r <= 2'b00;
    end else if (hs_trail) begin
      line_clamps_r <= 2'b00;
    end else if (clamp_pulse && line_clamps_r != 2'b11) begin
      line_clamps_r <= line_clamps_r + 2'b01;
    end
  end
  assign black_measure_on = auto_black_level_loop_en && width_r != 8'h00;

  // ************************************************************
  // Gain latch
  // ************************************************************
  logic [23:0] gain_r; // Active gain stage codes
  logic [23:0] idle_r; // Cycles since last gain update
  logic gain_pulse;

  // External clamp replaces the internal pulse when selected
  assign gain_pulse = (ext_clamp_sel ? ec_rise : clamp_pulse) || idle_r == 24'(GAIN_TIMEOUT - 1);

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      idle_r <= 24'h00_0000;
    end else if (gain_pulse) begin
      idle_r <= 24'h00_0000;
    end else begin
      idle_r <= idle_r + 24'h00_0001;
    end
  end

  // Gain = 0.5 + code/170 is analog; code passes through unchanged
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      gain_r <= {RST_GAIN, RST_GAIN, RST_GAIN};
    end else if (gain_pulse) begin
      gain_r <= {regs_r[IDX_RED_GAIN], regs_r[IDX_GREEN_GAIN], regs_r[IDX_BLUE_GAIN]};
    end
  end
  assign channel_gain_value = gain_r;

  // ************************************************************
  // Offset DAC steering and digital offset, per channel
  // ************************************************************
  logic [7:0] adj [0:2]; // Offset-corrected samples, 0 red 1 green 2 blue
  logic [7:0] raw [0:2];
  assign raw[0] = adc_pixel.red;
  assign raw[1] = adc_pixel.green;
  assign raw[2] = adc_pixel.blue;

  generate
    for (gi = 0; gi < 3; gi++) begin : g_ch
      logic [7:0] ofs;
      logic [9:0] sum;
      assign ofs = regs_r[IDX_RED_OFFSET + 6'(gi)];
      // Loop on: servo owns DAC; loop off: offset plus two low bits
      assign offset_dac_code[29 - 10 * gi -: 10] = auto_black_level_loop_en ?
        auto_black_level_loop_dac[29 - 10 * gi -: 10] :
        {ofs, regs_r[IDX_OFFSET_LOW_BITS_AND_RANGE][7 - 2 * gi -: 2]};
      // Chroma black sits at mid-scale; 0x80 offset adds nothing
      always_comb begin
        sum = {2'b00, raw[gi]};
        if (yuv_mode && gi != 1) begin
          sum = sum + {2'b00, MID_SCALE};
        end
        if (auto_black_level_loop_en) begin
          sum = sum + {2'b00, ofs} - {2'b00, MID_SCALE};
        end
        if (sum[9]) begin
          adj[gi] = 8'h00; // Underflow clips to zero
        end else if (sum[8]) begin
          adj[gi] = 8'hff; // Overflow clips to full scale
        end else begin
          adj[gi] = sum[7:0];
        end
      end
    end
  endgenerate

  // ************************************************************
  // Output format
  // ************************************************************
  logic odd_r; // Pixel parity within the line

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      odd_r <= 1'b0;
    end else if (hs_trail) begin
      odd_r <= 1'b0;
    end else begin
      odd_r <= !odd_r;
    end
  end

  // Channels keep their colour space; only 4:2:2 reshuffles chroma
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      out_pixel <= '0;
    end else begin
      out_pixel.green <= adj[1];
      if (fmt_422) begin
        out_pixel.blue <= 8'h00;
        out_pixel.red <= odd_r ? adj[0] : adj[2];
      end else begin
        out_pixel.blue <= adj[2];
        out_pixel.red <= adj[0];
      end
    end
  end

  assign status = {2'b00, act_sync_r[2][1], act_sync_r[1][1], act_sync_r[0][1],
                   coast_seen_r, armed_r, clamp_on};

  // ************************************************************
  // Assertions
  // ************************************************************
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  a_dc_no_clamp: assert property (dc_coupled |-> !clamp_on)
    else $error("clamp active while DC coupled");
  a_clamp_start: assert property (clamp_pulse && !dc_coupled && regs_r[IDX_CLAMP_WIDTH] != 8'h00
    |=> clamp_on)
    else $error("clamp did not start at start pixel");
  a_clamp_width: assert property ($rose(clamp_on) && regs_r[IDX_CLAMP_WIDTH] == 8'h05 && !dc_coupled
    ##0 !hs_trail [*5] |-> clamp_on ##1 !clamp_on)
    else $error("clamp width wrong");
  a_coast_block: assert property (pixel_clock_loop_coast && !clamp_in_coast |-> !clamp_pulse)
    else $error("clamp while coasting");
  a_line_once: assert property (line_clamps_r <= 2'b01)
    else $error("second clamp in one line");
  a_cnt_restart: assert property (hs_trail |=> pix_cnt_r == 16'h0000)
    else $error("counter not restarted");
  a_gain_hold: assert property (!gain_pulse |=> $stable(gain_r))
    else $error("gain changed without pulse");
  a_gain_bound: assert property (idle_r < 24'(GAIN_TIMEOUT))
    else $error("gain timeout exceeded");
  a_blue_low: assert property (fmt_422 |=> out_pixel.blue == 8'h00)
    else $error("blue not low in 4:2:2");
  a_chroma_mid: assert property (yuv_mode && !fmt_422 && raw[2] == 8'h00
    && regs_r[IDX_BLUE_OFFSET] == MID_SCALE |=> out_pixel.blue == MID_SCALE)
    else $error("chroma black not mid-scale");
  a_manual_dac: assert property (!auto_black_level_loop_en |->
    offset_dac_code[29:22] == regs_r[IDX_RED_OFFSET])
    else $error("manual DAC not from offset");
  a_meas_line: assert property (black_measure_on |-> auto_black_level_loop_en)
    else $error("measure with loop off");

  c_clamp: cover property ($rose(clamp_on));
  c_422: cover property (fmt_422 && yuv_mode ##1 clamp_on);
  c_timeout: cover property (idle_r == 24'(GAIN_TIMEOUT - 1));
  c_coast: cover property (win_start && suppress);

endmodule
`default_nettype wire

// >>> core/digitizer_ctrl_pkg.sv
// Purpose: Shared constants and types for the digitizer clamp and format control
// Assumes: Register indices are word indices; APB byte address is four times the index
// Notes: Reset values chosen so the block powers up AC coupled, RGB, full rate
package digitizer_ctrl_pkg;

  // ************************************************************
  // Register indices (byte address = index * 4)
  // ************************************************************
  localparam logic [5:0] IDX_SYNC_ON_GREEN_SLICER = 6'h04;
  localparam logic [5:0] IDX_INPUT_CONFIGURATION = 6'h05;
  localparam logic [5:0] IDX_RED_GAIN = 6'h06;
  localparam logic [5:0] IDX_GREEN_GAIN = 6'h07;
  localparam logic [5:0] IDX_BLUE_GAIN = 6'h08;
  localparam logic [5:0] IDX_RED_OFFSET = 6'h09;
  localparam logic [5:0] IDX_GREEN_OFFSET = 6'h0a;
  localparam logic [5:0] IDX_BLUE_OFFSET = 6'h0b;
  localparam logic [5:0] IDX_OFFSET_LOW_BITS_AND_RANGE = 6'h0c;
  localparam logic [5:0] IDX_BANDWIDTH_AND_PEAKING = 6'h0d;
  localparam logic [5:0] IDX_CLAMP_SOURCE_SELECT = 6'h13;
  localparam logic [5:0] IDX_CLAMP_START_PIXEL_HIGH = 6'h14;
  localparam logic [5:0] IDX_CLAMP_START_PIXEL_LOW = 6'h15;
  localparam logic [5:0] IDX_CLAMP_WIDTH = 6'h16;
  localparam logic [5:0] IDX_BLACK_LEVEL_LOOP_CONFIG = 6'h17;
  localparam logic [5:0] IDX_OUTPUT_FORMAT_CONFIG = 6'h18;
  localparam logic [5:0] IDX_CLAMP_IMPEDANCE = 6'h23;
  localparam logic [5:0] IDX_CONTROL_STATUS = 6'h30;

  // ************************************************************
  // Field positions
  // ************************************************************
  localparam int CFG_DC_COUPLED_BIT = 1;
  localparam int CFG_YUV_BIT = 2;
  localparam int CFG_CLAMP_IN_COAST_BIT = 5;
  localparam int FMT_422_BIT = 4;
  localparam int LOOP_DISABLE_BIT = 0;
  localparam int RANGE_HALF_BIT = 0;
  localparam int EXT_CLAMP_LSB = 4;

  // ************************************************************
  // Reset values and codes
  // ************************************************************
  localparam logic [7:0] RST_GAIN = 8'h55;
  localparam logic [7:0] RST_OFFSET = 8'h80;
  localparam logic [7:0] RST_BANDWIDTH = 8'h0e;
  localparam logic [7:0] RST_CLAMP_IMPEDANCE = 8'h08;
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic [7:0] MID_SCALE = 8'h80;

  // ************************************************************
  // Timing
  // ************************************************************
  localparam int CLK_PERIOD_NS = 10;
  localparam int GAIN_TIMEOUT_MS = 100;
  localparam int GAIN_TIMEOUT_CYC = GAIN_TIMEOUT_MS * 1000000 / CLK_PERIOD_NS;

  // One pixel of three converter channels
  typedef struct packed {
    logic [7:0] red;
    logic [7:0] green;
    logic [7:0] blue;
  } pixel_s;

endpackage

// >>> test/video_source.sv
// Purpose: Line-rate sync source standing in for the analog video feed
// Assumes: One pixel per sys_clk; sync pulse active high at line start
// Notes: Pin rests low while stopped, as an idle source leaves it
`timescale 1ns/1ps
`default_nettype none
module video_source #(
  parameter int LINE_CYC = 40,
  parameter int SYNC_CYC = 4
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic run,
  output logic hsync_out
);
  // ********************
  // Line timing
  // ********************
  int pos_r; // Pixel position within the line
  // Counter restarts when stopped so lines resume whole
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pos_r <= 0;
      hsync_out <= 1'b0;
    end else begin
      pos_r <= (!run || pos_r == LINE_CYC - 1) ? 0 : pos_r + 1;
      hsync_out <= run && (pos_r < SYNC_CYC);
    end
  end
endmodule
`default_nettype wire

// >>> test/tb_top.sv
// Purpose: Self-checking bench for the digitizer clamp and format control
// Assumes: Zero-wait APB, one pixel per clock, gain timeout cut to 50
// Notes: Drivers queue expected results, monitors pop and compare
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import digitizer_ctrl_pkg::*;
;
  localparam int LINE = 40; // Short lines keep the idle gain timer quiet
  localparam int GT = 50;
  typedef struct packed {pixel_s p; logic [7:0] alt;} exp_s;
  logic sys_clk, rst_n, psel, penable, pwrite, pready, pslverr, hsync_in;
  logic coast, run, clamp_on, black_measure_on, half_rng, abll_en;
  logic yuv, f422, loop_off, hs_d, cl_d, dc, bm_d;
  logic [2:0] imp_sel;
  logic [7:0] paddr, sog_cfg;
  logic [31:0] pwdata, prdata;
  logic [2:0] bw_sel;
  logic [3:0] pk_sel;
  logic [23:0] gains;
  logic [29:0] abll_dac, dac_code;
  pixel_s adc_pixel, out_pixel;
  logic [33:0] apb_q[$]; // {is_read, err, data}
  exp_s pix_q[$];
  logic [31:0] rnd = 32'h591654b0;
  int mismatches, n_tests, cyc, fall_t, dly, pulses, wcnt, last_w, d1, mpulses;
  int offv[3] = '{128, 128, 128};
  logic [5:0] ridx[11] = '{IDX_RED_GAIN, IDX_GREEN_GAIN, IDX_BLUE_GAIN, IDX_RED_OFFSET, IDX_GREEN_OFFSET,
    IDX_BLUE_OFFSET, IDX_BANDWIDTH_AND_PEAKING, IDX_INPUT_CONFIGURATION, IDX_CLAMP_IMPEDANCE,
    IDX_BLACK_LEVEL_LOOP_CONFIG, IDX_OUTPUT_FORMAT_CONFIG};
  logic [7:0] rval[11] = '{8'h55, 8'h55, 8'h55, 8'h80, 8'h80, 8'h80, 8'h0e, 8'h00, 8'h08, 8'h00, 8'h00};

  // ********************
  // Design and partner
  // ********************
  digitizer_ctrl #(.GAIN_TIMEOUT(GT)) uut (.sys_clk(sys_clk), .rst_n(rst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .hsync_in(hsync_in), .ext_clamp_in(1'b0),
    .pixel_clock_loop_coast(coast), .sync_activity(3'b101), .adc_pixel(adc_pixel),
    .auto_black_level_loop_dac(abll_dac), .out_pixel(out_pixel), .clamp_on(clamp_on),
    .black_measure_on(black_measure_on), .channel_gain_value(gains), .offset_dac_code(dac_code),
    .offset_dac_half_range(half_rng), .auto_black_level_loop_en(abll_en), .bandwidth_sel(bw_sel),
    .peaking_sel(pk_sel), .sync_on_green_cfg(sog_cfg), .clamp_impedance_sel(imp_sel));
  video_source #(.LINE_CYC(LINE), .SYNC_CYC(4)) src (.sys_clk(sys_clk), .rst_n(rst_n), .run(run),
    .hsync_out(hsync_in));
  // 100 MHz pixel clock
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  // ********************
  // Helpers and drivers
  // ********************
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return (s >> 1) ^ (s[0] ? 32'h80200003 : 32'h0);
  endfunction
  function automatic logic [7:0] clip(input int v);
    return v < 0 ? 8'h00 : v > 255 ? 8'hff : 8'(v);
  endfunction
  // Model of the digital path; alt holds the odd-pixel red in 4:2:2
  function automatic exp_s pix_exp(input pixel_s a);
    exp_s e;
    int c;
    c = yuv ? 128 : 0;
    e.p.red = clip(int'(a.red) + (loop_off ? 0 : offv[0] - 128) + c);
    e.p.green = clip(int'(a.green) + (loop_off ? 0 : offv[1] - 128));
    e.p.blue = clip(int'(a.blue) + (loop_off ? 0 : offv[2] - 128) + c);
    e.alt = e.p.red;
    if (f422) begin
      e.p.red = e.p.blue;
      e.p.blue = 8'h00;
    end
    return e;
  endfunction
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  // One APB transfer; idle edge after release avoids a double drive
  task automatic apb(input logic wr_en, input logic [7:0] a, input logic [31:0] d, input logic err);
    apb_q.push_back({!wr_en, err, d});
    psel <= 1'b1;
    pwrite <= wr_en;
    paddr <= a;
    pwdata <= wr_en ? d : 32'h0;
    @(posedge sys_clk);
    penable <= 1'b1;
    @(posedge sys_clk);
    while (pready !== 1'b1) @(posedge sys_clk);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic wr(input logic [5:0] i, input logic [7:0] v);
    apb(1'b1, {i, 2'b00}, {24'h0, v}, 1'b0);
  endtask
  task automatic rd(input logic [5:0] i, input logic [7:0] v);
    apb(1'b0, {i, 2'b00}, {24'h0, v}, 1'b0);
  endtask
  // Random pixels, each noted with its expected output
  task automatic stream(input int n);
    repeat (n) begin
      @(posedge sys_clk);
      rnd = lfsr(rnd);
      adc_pixel <= rnd[23:0];
      pix_q.push_back(pix_exp(rnd[23:0]));
    end
    repeat (2) @(posedge sys_clk);
    pix_q.delete();
  endtask
  // One settling line, then count clamp pulses over whole lines
  task automatic run_lines(input int n, input int exp_p, input int exp_m);
    int p0, m0;
    repeat (LINE) @(posedge sys_clk);
    p0 = pulses;
    m0 = mpulses;
    repeat (n * LINE) @(posedge sys_clk);
    chk("clamp pulses", exp_p, pulses - p0);
    chk("measure pulses", exp_m, mpulses - m0);
  endtask
  task automatic stop_test();
    $display("Counts: mismatches=%0d n_tests=%0d", mismatches, n_tests);
    if (mismatches == 0 && n_tests > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // ********************
  // Monitors
  // ********************
  // APB answers against queued notes
  always @(posedge sys_clk) begin
    logic [33:0] e;
    if (psel && penable && pready === 1'b1) begin
      e = apb_q.pop_front();
      if (e[33]) chk("prdata", e[31:0], prdata);
      chk("pslverr", {31'h0, e[32]}, {31'h0, pslverr});
    end
  end
  // Falling edge sampling keeps clamp counts free of races
  always @(negedge sys_clk) begin
    exp_s e;
    pixel_s g;
    cyc++;
    if (hs_d === 1'b1 && hsync_in === 1'b0) fall_t = cyc;
    if (clamp_on === 1'b1 && cl_d !== 1'b1) begin
      dly = cyc - fall_t;
      pulses++;
    end
    if (black_measure_on === 1'b1 && bm_d !== 1'b1) mpulses++;
    bm_d = black_measure_on;
    if (clamp_on === 1'b1) wcnt++;
    else if (cl_d === 1'b1) begin
      last_w = wcnt;
      wcnt = 0;
    end
    hs_d = hsync_in;
    cl_d = clamp_on;
    if (rst_n && !dc) chk("black_measure_on", {31'h0, !loop_off && clamp_on}, {31'h0, black_measure_on});
    while (pix_q.size() > 1) begin
      e = pix_q.pop_front();
      g = out_pixel;
      if (g.red === e.alt) g.red = e.p.red;
      chk("out_pixel", {8'h0, e.p}, {8'h0, g});
    end
  end
  // Hang guard, far beyond the expected 1000 or so cycles
  initial begin
    #100us;
    mismatches++;
    $display("[ERR] watchdog expected finish seen hang");
    stop_test();
  end

  // ********************
  // Main sequence
  // ********************
  initial begin
    {psel, penable, pwrite, coast, run, yuv, f422, loop_off, dc} = '0;
    paddr = '0;
    pwdata = '0;
    adc_pixel = '0;
    rst_n = 1'b0;
    rnd = lfsr(rnd);
    abll_dac = rnd[29:0];
    repeat (5) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    foreach (ridx[k]) rd(ridx[k], rval[k]);
    rd(IDX_CONTROL_STATUS, 8'h28);
    chk("bandwidth_sel", 32'h7, {29'h0, bw_sel});
    chk("clamp_impedance_sel", 32'h0, {29'h0, imp_sel});
    chk("loop_en", 32'h1, {31'h0, abll_en});
    chk("dac_code", {2'h0, abll_dac}, {2'h0, dac_code});
    chk("gains", 32'h555555, {8'h0, gains});
    apb(1'b0, 8'hfc, 32'h0, 1'b1); // Unmapped read refused
    apb(1'b1, 8'h15, 32'hff, 1'b1); // Misaligned write refused
    rd(IDX_INPUT_CONFIGURATION, 8'h00);
    wr(IDX_BANDWIDTH_AND_PEAKING, 8'ha5);
    chk("bandwidth_sel", 32'h2, {29'h0, bw_sel});
    chk("peaking_sel", 32'ha, {28'h0, pk_sel});
    wr(IDX_SYNC_ON_GREEN_SLICER, 8'h16);
    chk("sync_on_green_cfg", 32'h16, {24'h0, sog_cfg});
    offv = '{'h90, 'h70, 'h85};
    wr(IDX_RED_OFFSET, 8'h90);
    wr(IDX_GREEN_OFFSET, 8'h70);
    wr(IDX_BLUE_OFFSET, 8'h85);
    wr(IDX_OFFSET_LOW_BITS_AND_RANGE, 8'he5);
    // RGB, YUV, YUV 4:2:2, then RGB with the loop off
    for (int m = 0; m < 4; m++) begin
      yuv = (m == 1 || m == 2);
      f422 = (m == 2);
      loop_off = (m == 3);
      wr(IDX_INPUT_CONFIGURATION, {5'h0, yuv, 2'h0});
      wr(IDX_OUTPUT_FORMAT_CONFIG, {3'h0, f422, 4'h0});
      wr(IDX_BLACK_LEVEL_LOOP_CONFIG, {7'h0, loop_off});
      stream(24);
    end
    chk("dac_code", {2'h0, 8'h90, 2'h3, 8'h70, 2'h2, 8'h85, 2'h1}, {2'h0, dac_code});
    chk("half_range", 32'h1, {31'h0, half_rng});
    chk("loop_en", 32'h0, {31'h0, abll_en});
    loop_off = 1'b0;
    wr(IDX_BLACK_LEVEL_LOOP_CONFIG, 8'h00);
    run <= 1'b1;
    wr(IDX_CLAMP_START_PIXEL_LOW, 8'h03);
    wr(IDX_CLAMP_WIDTH, 8'h05);
    run_lines(3, 3, 3);
    chk("clamp width", 32'd5, last_w);
    d1 = dly;
    wr(IDX_CLAMP_START_PIXEL_LOW, 8'h09);
    run_lines(2, 2, 2);
    chk("clamp start shift", 32'd6, dly - d1);
    coast <= 1'b1;
    run_lines(2, 0, 0);
    wr(IDX_INPUT_CONFIGURATION, 8'h20);
    run_lines(2, 2, 2);
    coast <= 1'b0;
    dc = 1'b1;
    wr(IDX_INPUT_CONFIGURATION, 8'h02);
    run_lines(2, 0, 2);
    wr(IDX_INPUT_CONFIGURATION, 8'h00);
    dc = 1'b0;
    @(negedge clamp_on);
    @(posedge sys_clk);
    wr(IDX_RED_GAIN, 8'h60);
    chk("red gain held", 32'h55, {24'h0, gains[23:16]});
    @(posedge clamp_on);
    repeat (3) @(posedge sys_clk);
    chk("red gain applied", 32'h60, {24'h0, gains[23:16]});
    run <= 1'b0;
    wr(IDX_BLUE_GAIN, 8'h33);
    repeat (GT + 20) @(posedge sys_clk);
    chk("blue gain timeout", 32'h33, {24'h0, gains[7:0]});
    stop_test();
  end
endmodule
`default_nettype wire
